// ==== design/iqacf_framer.sv ====
// downlink framer packing i/q samples into antenna-carrier containers
// Function
// - word width follows selected line rate multiple
// - wide containers spill into following words
// - containers per frame scale with oversampling
// - required rate is rate*res*2*oversampling
// - assigned rate is 3.84MHz*res*2*containers
// - match flag; setup valid only when rates equal averaged over the group cycle
// - container placed by word and bit address
// - flag overlap or misfit; never transmit it
// - enable brings link up, then samples flow
// - optional start condition holds sample transmission
// - apply restarts link with new settings
// - pending flag while settings differ from applied
// - one basic frame per 3.84MHz chip period
// - groups have repetitions; off groups send empty
// - groups cycle continuously in order
// - group settings written directly by ports
// - sixteen words; word zero is control
// - word address is first occupied word
`timescale 1ns/1ps
`include "iqacf_defines.svh"
module iqacf_framer
  import iqacf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic clk_link,
  input wire logic sig_en,
  input wire logic apply,
  input wire logic [2:0] cfg_rate,
  input wire logic [4:0] cfg_res,
  input wire logic cfg_fmt,
  input wire logic [2:0] cfg_os,
  input wire logic [19:0] cfg_sr_khz,
  input wire logic [2:0] cfg_naxc,
  input wire logic [15:0] cfg_waddr,
  input wire logic [27:0] cfg_baddr,
  input wire logic [2:0] cfg_ngrp,
  input wire logic [15:0] cfg_grp_rep,
  input wire logic [3:0] cfg_grp_on,
  input wire logic cfg_trig_mode,
  input wire logic ext_trig,
  input wire logic link_ok,
  input wire logic [127:0] ctl_word,
  input wire logic smp_valid,
  input wire logic [15:0] smp_i,
  input wire logic [15:0] smp_q,
  output logic smp_ready,
  output logic link_en,
  output logic tx_active,
  output logic rate_match,
  output logic [3:0] conflict,
  output logic pending,
  output logic underflow,
  output logic [28:0] req_rate_kbps,
  output logic [28:0] asg_rate_kbps,
  output logic [127:0] link_word,
  output logic link_word_vld,
  output logic link_sof
);

  function automatic logic [7:0] wlen_of(input logic [2:0] code);
    logic [7:0] w;
    w = `IQACF_WLEN_1X;
    unique case (code)
      IQACF_R1X: w = `IQACF_WLEN_1X;
      IQACF_R2X: w = `IQACF_WLEN_2X;
      IQACF_R4X: w = `IQACF_WLEN_4X;
      IQACF_R5X: w = `IQACF_WLEN_5X;
      IQACF_R8X: w = `IQACF_WLEN_8X;
      IQACF_R10X: w = `IQACF_WLEN_10X;
      IQACF_R16X: w = `IQACF_WLEN_16X;
      default: w = `IQACF_WLEN_1X;
    endcase
    return w;
  endfunction : wlen_of

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and applied settings

  logic trig_s1_q, trig_s2_q, trig_s3_q, lok_s1_q, lok_s2_q;
  iqacf_state_t st_q, st_d;
  logic [2:0] a_rate_q, a_naxc_q, a_ngrp_q;
  logic [4:0] a_res_q;
  logic a_fmt_q, a_trig_q;
  logic [15:0] a_waddr_q, a_grp_rep_q;
  logic [27:0] a_baddr_q;
  logic [3:0] a_grp_on_q;
  logic [2:0] a_os_q;
  logic [19:0] a_sr_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
      lok_s1_q <= 1'b0;
      lok_s2_q <= 1'b0;
    end else if (clk_en) begin
      trig_s1_q <= ext_trig;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      lok_s1_q <= link_ok;
      lok_s2_q <= lok_s1_q;
    end
  end

  wire trig_edge = trig_s2_q & ~trig_s3_q;
  wire [7:0] cwlen = wlen_of(cfg_rate);
  wire [7:0] awlen = wlen_of(a_rate_q);

  ////////////////////////////////////////////////////////////////////////////////
  // placement check on the edited settings

  logic [10:0] pos [`IQACF_NAXC];
  logic [11:0] pend [`IQACF_NAXC];
  logic [3:0] conf_w;
  wire [11:0] fend = 12'(`IQACF_NWORD) * {4'h0, cwlen};

  for (genvar k = 0; k < `IQACF_NAXC; k++) begin : g_chk
    wire [3:0] wa = cfg_waddr[4*k +: 4];
    wire [6:0] ba = cfg_baddr[7*k +: 7];
    assign pos[k] = 11'(wa) * 11'(cwlen) + 11'(ba);
    assign pend[k] = {1'b0, pos[k]} + {6'h00, cfg_res, 1'b0};
    wire used = 3'(k) < cfg_naxc;
    wire misfit = (wa == 4'h0) || ({1'b0, ba} >= cwlen) || (pend[k] > fend);
    logic ovl;
    always_comb begin
      ovl = 1'b0;
      for (int j = 0; j < `IQACF_NAXC; j++) begin
        if (j != k && 3'(j) < cfg_naxc && {1'b0, pos[k]} < pend[j] && {1'b0, pos[j]} < pend[k])
          ovl = 1'b1;
      end
    end
    assign conf_w[k] = used & (misfit | ovl);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data rates and pending change

  logic [5:0] tot_rep, on_rep;
  always_comb begin
    tot_rep = 6'h00;
    on_rep = 6'h00;
    for (int g = 0; g < `IQACF_NGRP; g++) begin
      if (3'(g) < cfg_ngrp) begin
        tot_rep = tot_rep + {2'b00, cfg_grp_rep[4*g +: 4]};
        if (cfg_grp_on[g])
          on_rep = on_rep + {2'b00, cfg_grp_rep[4*g +: 4]};
      end
    end
  end

  wire [28:0] req_w = 29'(cfg_sr_khz * cfg_res * 2 * cfg_os);
  wire [28:0] asg_w = 29'(`IQACF_BF_KHZ * cfg_res * 2 * cfg_naxc);
  wire [34:0] req_avg = 35'(req_w) * 35'(tot_rep);
  wire [34:0] asg_avg = 35'(asg_w) * 35'(on_rep);
  wire match_w = (req_avg == asg_avg) && (tot_rep != 6'h00);
  wire apply_ok = apply & match_w & (conf_w == 4'h0);
  wire differ = {cfg_rate, cfg_naxc, cfg_ngrp, cfg_res, cfg_fmt, cfg_trig_mode, cfg_waddr,
    cfg_grp_rep, cfg_baddr, cfg_grp_on, cfg_os, cfg_sr_khz} !=
    {a_rate_q, a_naxc_q, a_ngrp_q, a_res_q, a_fmt_q, a_trig_q, a_waddr_q,
    a_grp_rep_q, a_baddr_q, a_grp_on_q, a_os_q, a_sr_q};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {a_rate_q, a_naxc_q, a_ngrp_q, a_res_q, a_fmt_q, a_trig_q} <= '0;
      {a_waddr_q, a_grp_rep_q, a_baddr_q, a_grp_on_q, a_os_q, a_sr_q} <= '0;
      rate_match <= 1'b0;
      conflict <= 4'h0;
      pending <= 1'b0;
      req_rate_kbps <= 29'h0;
      asg_rate_kbps <= 29'h0;
    end else if (clk_en) begin
      if (apply_ok) begin
        {a_rate_q, a_naxc_q, a_ngrp_q, a_res_q, a_fmt_q, a_trig_q} <=
          {cfg_rate, cfg_naxc, cfg_ngrp, cfg_res, cfg_fmt, cfg_trig_mode};
        {a_waddr_q, a_grp_rep_q, a_baddr_q, a_grp_on_q, a_os_q, a_sr_q} <=
          {cfg_waddr, cfg_grp_rep, cfg_baddr, cfg_grp_on, cfg_os, cfg_sr_khz};
      end
      rate_match <= match_w;
      conflict <= conf_w;
      pending <= differ & ~apply_ok;
      req_rate_kbps <= req_w;
      asg_rate_kbps <= asg_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link control sequence

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      IQACF_ST_OFF: if (sig_en) st_d = IQACF_ST_UP;
      IQACF_ST_UP: begin
        if (!sig_en) st_d = IQACF_ST_OFF;
        else if (lok_s2_q) st_d = a_trig_q ? IQACF_ST_WAIT : IQACF_ST_RUN;
      end
      IQACF_ST_WAIT: begin
        if (!sig_en) st_d = IQACF_ST_OFF;
        else if (!lok_s2_q) st_d = IQACF_ST_UP;
        else if (trig_edge) st_d = IQACF_ST_RUN;
      end
      IQACF_ST_RUN: begin
        if (!sig_en) st_d = IQACF_ST_OFF;
        else if (!lok_s2_q) st_d = IQACF_ST_UP;
      end
      IQACF_ST_DOWN: if (!lok_s2_q) st_d = sig_en ? IQACF_ST_UP : IQACF_ST_OFF;
      default: st_d = IQACF_ST_OFF;
    endcase
    if (apply_ok) st_d = IQACF_ST_DOWN;
  end

  wire run = (st_q == IQACF_ST_RUN);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= IQACF_ST_OFF;
      link_en <= 1'b0;
      tx_active <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      link_en <= (st_d != IQACF_ST_OFF) && (st_d != IQACF_ST_DOWN);
      tx_active <= (st_d == IQACF_ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // chip-rate timebase and group sequencer

  logic [16:0] acc_q;
  wire [17:0] acc_sum = {1'b0, acc_q} + 18'(`IQACF_BF_KHZ);
  wire tick = acc_sum >= 18'(`IQACF_CLK_KHZ);
  logic [1:0] grp_q;
  logic [3:0] rep_q;
  wire [3:0] rep_lim = a_grp_rep_q[4*grp_q +: 4];
  wire grp_on = a_grp_on_q[grp_q];
  wire rep_last = (rep_q + 4'h1 >= rep_lim);
  wire grp_last = (3'(grp_q) + 3'h1 >= a_ngrp_q);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= 17'h0;
      grp_q <= 2'h0;
      rep_q <= 4'h0;
    end else if (clk_en) begin
      acc_q <= tick ? 17'(acc_sum - 18'(`IQACF_CLK_KHZ)) : acc_sum[16:0];
      if (!run) begin
        grp_q <= 2'h0;
        rep_q <= 4'h0;
      end else if (tick) begin
        rep_q <= rep_last ? 4'h0 : rep_q + 4'h1;
        if (rep_last) grp_q <= grp_last ? 2'h0 : grp_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sample intake and frame assembly

  logic [31:0] slot_q [`IQACF_NAXC];
  logic [2:0] fill_q;
  wire take = smp_valid & smp_ready;
  wire send_smp = run & tick & grp_on & (fill_q == a_naxc_q);
  wire [2:0] fill_nx = send_smp ? 3'h0 : (take ? fill_q + 3'h1 : fill_q);
  wire [15:0] rmask = 16'((17'h1 << a_res_q) - 17'h1);
  wire [15:0] fmtflip = (a_fmt_q == `IQACF_FMT_OFFS) ? 16'(17'h1 << (a_res_q - 5'h1)) : 16'h0;
  wire [15:0] i_f = (smp_i ^ fmtflip) & rmask;
  wire [15:0] q_f = (smp_q ^ fmtflip) & rmask;
  wire [31:0] packed_w = 32'({16'h0, q_f} << a_res_q) | {16'h0, i_f};
  wire [127:0] wmask = 128'((129'h1 << awlen) - 129'h1);

  logic [`IQACF_FBITS-1:0] frm_w;
  always_comb begin
    frm_w = '0;
    frm_w[127:0] = ctl_word & wmask;
    if (send_smp) begin
      for (int k = 0; k < `IQACF_NAXC; k++) begin
        if (3'(k) < a_naxc_q)
          frm_w = frm_w | (`IQACF_FBITS'(slot_q[k]) <<
            (11'(a_waddr_q[4*k +: 4]) * 11'(awlen) + 11'(a_baddr_q[7*k +: 7])));
      end
    end
  end

  logic [`IQACF_FBITS-1:0] frm_q;
  logic [7:0] frm_wlen_q;
  logic frm_tgl_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int k = 0; k < `IQACF_NAXC; k++) slot_q[k] <= 32'h0;
      fill_q <= 3'h0;
      smp_ready <= 1'b0;
      underflow <= 1'b0;
      frm_q <= '0;
      frm_wlen_q <= `IQACF_WLEN_1X;
      frm_tgl_q <= 1'b0;
    end else if (clk_en) begin
      if (take) slot_q[fill_q[1:0]] <= packed_w;
      fill_q <= run ? fill_nx : 3'h0;
      smp_ready <= run && (fill_nx < a_naxc_q);
      if (run & tick & grp_on & (fill_q != a_naxc_q)) underflow <= 1'b1;
      else if (apply_ok) underflow <= 1'b0;
      if (tick && link_en) begin
        frm_q <= frm_w;
        frm_wlen_q <= awlen;
        frm_tgl_q <= ~frm_tgl_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link clock domain: word serialiser

  logic lt_s1_q, lt_s2_q, lt_s3_q;
  logic [`IQACF_FBITS-1:0] lfrm_q;
  logic [7:0] lwlen_q;
  logic [4:0] widx_q;
  wire lnew = lt_s2_q ^ lt_s3_q;
  wire [127:0] lmask = 128'((129'h1 << lwlen_q) - 129'h1);

  always_ff @(posedge clk_link or negedge arst_n) begin
    if (!arst_n) begin
      lt_s1_q <= 1'b0;
      lt_s2_q <= 1'b0;
      lt_s3_q <= 1'b0;
      lfrm_q <= '0;
      lwlen_q <= `IQACF_WLEN_1X;
      widx_q <= 5'h10;
      link_word <= 128'h0;
      link_word_vld <= 1'b0;
      link_sof <= 1'b0;
    end else begin
      lt_s1_q <= frm_tgl_q;
      lt_s2_q <= lt_s1_q;
      lt_s3_q <= lt_s2_q;
      link_sof <= 1'b0;
      link_word_vld <= 1'b0;
      if (lnew) begin
        lfrm_q <= frm_q;
        lwlen_q <= frm_wlen_q;
        widx_q <= 5'h0;
      end else if (widx_q < 5'(`IQACF_NWORD)) begin
        link_word <= 128'(lfrm_q >> (11'(widx_q) * 11'(lwlen_q))) & lmask;
        link_word_vld <= 1'b1;
        link_sof <= (widx_q == 5'h0);
        widx_q <= widx_q + 5'h1;
      end
    end
  end

endmodule : iqacf_framer

// ==== design/iqacf_defines.svh ====
// constants of the antenna-carrier framer
`ifndef IQACF_DEFINES_SVH
`define IQACF_DEFINES_SVH
`define IQACF_NAXC 4
`define IQACF_NGRP 4
`define IQACF_NWORD 16
`define IQACF_WMAX 128
`define IQACF_FBITS 2048
`define IQACF_CLK_KHZ 125000
`define IQACF_BF_KHZ 3840
`define IQACF_WLEN_1X 8'h08
`define IQACF_WLEN_2X 8'h10
`define IQACF_WLEN_4X 8'h20
`define IQACF_WLEN_5X 8'h28
`define IQACF_WLEN_8X 8'h40
`define IQACF_WLEN_10X 8'h50
`define IQACF_WLEN_16X 8'h80
`define IQACF_FMT_TWOS 1'b0
`define IQACF_FMT_OFFS 1'b1
`endif

// ==== design/iqacf_pkg.sv ====
// types of the antenna-carrier framer
package iqacf_pkg;
  typedef enum logic [2:0] {
    IQACF_ST_OFF = 3'b000,
    IQACF_ST_UP = 3'b001,
    IQACF_ST_WAIT = 3'b010,
    IQACF_ST_RUN = 3'b011,
    IQACF_ST_DOWN = 3'b100
  } iqacf_state_t;
  typedef enum logic [2:0] {
    IQACF_R1X = 3'b000,
    IQACF_R2X = 3'b001,
    IQACF_R4X = 3'b010,
    IQACF_R5X = 3'b011,
    IQACF_R8X = 3'b100,
    IQACF_R10X = 3'b101,
    IQACF_R16X = 3'b110
  } iqacf_rate_t;
endpackage : iqacf_pkg

// ==== verif/iqacf_framer_chk.sv ====
// port assertions for the antenna-carrier framer
`timescale 1ns/1ps
module iqacf_chk
  import iqacf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic clk_link,
  input wire logic sig_en,
  input wire logic apply,
  input wire logic [4:0] cfg_res,
  input wire logic [2:0] cfg_os,
  input wire logic [19:0] cfg_sr_khz,
  input wire logic [2:0] cfg_naxc,
  input wire logic link_en,
  input wire logic tx_active,
  input wire logic rate_match,
  input wire logic [3:0] conflict,
  input wire logic pending,
  input wire logic [28:0] req_rate_kbps,
  input wire logic [28:0] asg_rate_kbps,
  input wire logic link_word_vld,
  input wire logic link_sof
);
  wire take_apply = clk_en && apply && rate_match && conflict == 4'h0;
  a_req_rate: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clk_en |=> req_rate_kbps == 29'($past(cfg_sr_khz) * $past(cfg_res) * 2 * $past(cfg_os)))
    else $error("required rate wrong");
  a_asg_rate: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clk_en |=> asg_rate_kbps == 29'(3840 * $past(cfg_res) * 2 * $past(cfg_naxc)))
    else $error("assigned rate wrong");
  a_tx_link: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tx_active |-> link_en) else $error("samples without link");
  a_sof_first: assert property (@(posedge clk_link) disable iff (!arst_n)
    link_sof |-> link_word_vld) else $error("frame start without word");
  a_word_train: assert property (@(posedge clk_link) disable iff (!arst_n)
    link_sof |=> link_word_vld [*8]) else $error("frame words broken");
  a_pend_clr: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_apply |=> !pending) else $error("pending kept after apply");
  a_apply_drop: assert property (@(posedge clk_sys) disable iff (!arst_n)
    take_apply |=> !link_en && !tx_active) else $error("link kept after apply");
  a_refuse_keep: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clk_en && apply && !rate_match && sig_en && link_en |=> link_en)
    else $error("mismatched apply taken");
  c_run: cover property (@(posedge clk_sys) $rose(tx_active));
  c_refuse: cover property (@(posedge clk_sys) apply && !rate_match);
  c_frame: cover property (@(posedge clk_link) link_sof);
endmodule : iqacf_chk
bind iqacf_framer iqacf_chk u_chk (.clk_sys, .arst_n, .clk_en, .clk_link, .sig_en, .apply,
  .cfg_res, .cfg_os, .cfg_sr_khz, .cfg_naxc, .link_en, .tx_active, .rate_match, .conflict,
  .pending, .req_rate_kbps, .asg_rate_kbps, .link_word_vld, .link_sof);

// ==== verif/iqacf_rre.sv ====
// remote radio equipment model at the far end of the link
`timescale 1ns/1ps
module iqacf_rre
  import iqacf_pkg::*;
(
  input wire logic clk_link,
  input wire logic arst_n,
  input wire logic link_en,
  input wire logic [7:0] up_dly,
  input wire logic [127:0] link_word,
  input wire logic link_word_vld,
  input wire logic link_sof,
  output logic link_ok,
  output logic [15:0] fr_cnt,
  output logic [127:0] fr_w [16]
);
  logic [1:0] en_q;
  logic [7:0] up_q;
  logic [3:0] idx_q;
  wire [3:0] slot = link_sof ? 4'h0 : idx_q;
  always_ff @(posedge clk_link or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= 2'h0;
      up_q <= 8'h0;
      link_ok <= 1'b0;
      idx_q <= 4'h0;
      fr_cnt <= 16'h0;
    end else begin
      en_q <= {en_q[0], link_en};
      up_q <= en_q[1] ? up_q + {7'h0, up_q != up_dly} : 8'h0;
      link_ok <= en_q[1] && (link_ok || up_q == up_dly);
      if (link_word_vld) begin
        idx_q <= slot + 4'h1;
        if (slot == 4'hf) fr_cnt <= fr_cnt + 16'h1;
      end
    end
  end
  always_ff @(posedge clk_link) begin
    if (link_word_vld) fr_w[slot] <= link_word;
  end
endmodule : iqacf_rre

// ==== verif/tb_iqacf_framer.sv ====
// self-checking bench of the antenna-carrier framer
`timescale 1ns/1ps
module tb_iqacf_framer import iqacf_pkg::*;;
  logic clk_sys = 1'b0, clk_link = 1'b0, arst_n = 1'b0, sig_en = 1'b0, apply = 1'b0;
  logic cfg_trig_mode = 1'b0, ext_trig = 1'b0, smp_valid = 1'b0;
  logic [2:0] cfg_rate = 3'h0, cfg_os = 3'h2, cfg_naxc = 3'h2, cfg_ngrp = 3'h1;
  logic [15:0] cfg_waddr = 16'h0051, cfg_grp_rep = 16'h0001, smp_i = 16'h1230, fr_cnt;
  logic [3:0] cfg_grp_on = 4'hf, conflict;
  logic [19:0] cfg_sr_khz = 20'h00f00;
  logic [4:0] cfg_res = 5'h10;
  logic cfg_fmt = 1'b0;
  logic [27:0] cfg_baddr = 28'h0;
  logic [127:0] ctl_word = 128'h0, link_word;
  logic [127:0] fr_w [16];
  logic [28:0] req_rate_kbps, asg_rate_kbps;
  logic [7:0] up_dly = 8'h03;
  logic smp_ready, link_en, tx_active, rate_match, pending, link_word_vld, link_sof, link_ok;
  logic underflow;
  logic [2047:0] f, e;
  int failures = 0, cmp_count = 0, cyc = 0, r, k, n;
  int wl [7] = '{8, 16, 32, 40, 64, 80, 128};
  iqacf_framer dut (.clk_sys, .arst_n, .clk_en(1'b1), .clk_link, .sig_en, .apply, .cfg_rate,
    .cfg_res, .cfg_fmt, .cfg_os, .cfg_sr_khz, .cfg_naxc, .cfg_waddr,
    .cfg_baddr, .cfg_ngrp, .cfg_grp_rep, .cfg_grp_on, .cfg_trig_mode, .ext_trig,
    .link_ok, .ctl_word, .smp_valid, .smp_i, .smp_q(16'habcd), .smp_ready, .link_en,
    .tx_active, .rate_match, .conflict, .pending, .underflow, .req_rate_kbps,
    .asg_rate_kbps, .link_word, .link_word_vld, .link_sof);
  iqacf_rre u_rre (.clk_link, .arst_n, .link_en, .up_dly, .link_word, .link_word_vld,
    .link_sof, .link_ok, .fr_cnt, .fr_w);
  initial forever #4 clk_sys = ~clk_sys;
  initial begin
    #3;
    forever #6 clk_link = ~clk_link;
  end
  task automatic tick(input int c = 1);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input logic [2047:0] s, input logic [2047:0] x, input string m);
    cmp_count++;
    if (s !== x) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic final_report;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic do_apply;
    apply = 1'b1;
    tick();
    apply = 1'b0;
    tick();
  endtask : do_apply
  task automatic wait_run;
    for (k = 0; k < 3000 && tx_active !== 1'b1; k++) tick();
  endtask : wait_run
  task automatic grab(input int w);
    n = fr_cnt;
    for (k = 0; k < 500 && fr_cnt == n; k++) tick();
    f = '0;
    for (k = 0; k < 16; k++) f |= 2048'(fr_w[k] & ((128'h1 << w) - 128'h1)) << (k * w);
  endtask : grab
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      final_report();
    end
  end
  ////////////////////////////////////////
  initial begin
    tick(20);
    arst_n = 1'b1;
    smp_valid = 1'b1;
    sig_en = 1'b1;
    for (r = 0; r < 7; r++) begin
      cfg_rate = 3'(r);
      smp_i = 16'h1230 + 16'(r);
      ctl_word = {32{4'(r + 5)}};
      tick(3);
      chk(rate_match, 1'b1, "match");
      chk(conflict, 4'h0, "conflict");
      chk(pending, 1'b1, "pending set");
      do_apply();
      chk(pending, 1'b0, "pending clear");
      wait_run();
      chk(tx_active, 1'b1, "run");
      repeat (3) grab(wl[r]);
      e = {16'habcd, smp_i};
      chk(f, (e << (wl[r] * 5)) | (e << wl[r]) | (ctl_word & ((128'h1 << wl[r]) - 128'h1)),
        "frame");
    end
    chk(req_rate_kbps, 29'h3c000, "req rate");
    chk(asg_rate_kbps, 29'h3c000, "asg rate");
    $display("test rates done");
    cfg_rate = 3'h1;
    cfg_sr_khz = 20'h01680;
    cfg_os = 3'h1;
    cfg_ngrp = 3'h2;
    cfg_grp_rep = 16'h0013;
    cfg_grp_on = 4'h1;
    tick(3);
    chk(rate_match, 1'b1, "group match");
    chk(req_rate_kbps, 29'h2d000, "group req");
    do_apply();
    wait_run();
    e = '0;
    for (r = 0; r < 16; r++) begin
      grab(16);
      e[r] = f[31:16] == 16'h0;
    end
    chk(e[15:8], e[11:4], "group cycle");
    chk($countones(e[11:4]), 2, "empty count");
    $display("test groups done");
    cfg_naxc = 3'h1;
    tick(3);
    chk(rate_match, 1'b0, "mismatch");
    do_apply();
    chk(pending, 1'b1, "refused");
    chk(tx_active, 1'b1, "still on");
    cfg_naxc = 3'h2;
    cfg_waddr = 16'h0021;
    tick(3);
    chk(conflict, 4'h3, "overlap");
    cfg_waddr = 16'h0050;
    tick(3);
    chk(conflict[0], 1'b1, "word zero");
    do_apply();
    chk(tx_active, 1'b1, "conflict refused");
    $display("test refusals done");
    cfg_waddr = 16'h0051;
    cfg_baddr = 28'h0000004;
    cfg_res = 5'h0c;
    cfg_fmt = 1'b1;
    cfg_sr_khz = 20'h00f00;
    cfg_os = 3'h2;
    cfg_ngrp = 3'h1;
    cfg_grp_rep = 16'h0003;
    cfg_trig_mode = 1'b1;
    up_dly = 8'h28;
    tick(3);
    chk(rate_match, 1'b1, "format match");
    chk(asg_rate_kbps, 29'h2d000, "res asg");
    do_apply();
    for (k = 0; k < 300 && link_ok !== 1'b0; k++) tick();
    for (k = 0; k < 3000 && link_ok !== 1'b1; k++) tick();
    tick(40);
    chk(tx_active, 1'b0, "held");
    chk(smp_ready, 1'b0, "no intake held");
    chk(link_en, 1'b1, "link held up");
    ext_trig = 1'b1;
    wait_run();
    chk(tx_active, 1'b1, "triggered");
    repeat (3) grab(16);
    e = 2048'(24'h3cda36);
    chk(f, (e << 80) | (e << 20) | 2048'(ctl_word[15:0]), "format frame");
    smp_valid = 1'b0;
    repeat (2) grab(16);
    chk(underflow, 1'b1, "underflow");
    chk(f, 2048'(ctl_word[15:0]), "empty frame");
    $display("test trigger done");
    final_report();
  end
endmodule : tb_iqacf_framer
